/* include/rail_pkg.sv */
// Purpose : Shared constants and types for the rail control and power-good delay registers
// Assumes : 40 MHz system clock, byte-wide register port
// Notes   : Delay codes map to whole multiples of a 5 ms step

package rail_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;              // 40 MHz
  localparam int DLY_STEP_MS   = 5;               // Every delay is a multiple of this
  localparam int DLY_STEP_CYCLES = DLY_STEP_MS * 1000000 / CLK_PERIOD_NS;
  // Delay table in milliseconds, as programmed
  localparam int DLY_MS_0 = 0;
  localparam int DLY_MS_1 = 5;
  localparam int DLY_MS_2 = 10;
  localparam int DLY_MS_3 = 15;
  localparam int DLY_MS_4 = 20;
  localparam int DLY_MS_5 = 50;
  localparam int DLY_MS_6 = 75;
  localparam int DLY_MS_7 = 100;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL  = 8'h9c;      // step_down_ctrl_mode_disable
  localparam logic [7:0] ADDR_DELAY = 8'h9d;      // power_good_delay_second
  localparam logic [7:0] ADDR_SWDIS = 8'h9f;      // switch_termination_disable

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_MODE_LSB  = 3;              // Mode bits 5:3, controller one at 3
  localparam int CTRL_DIS_LSB   = 0;              // Disable bits 2:0, controller one at 0
  localparam int CTRL_WIDTH     = 6;              // Bits 7:6 reserved
  localparam int DLY_TWO_LSB    = 5;              // Bits 7:5
  localparam int DLY_FOUR_LSB   = 2;              // Bits 4:2
  localparam int DLY_ONE_LSB    = 0;              // Bits 1:0
  localparam int SW_TERM_BIT    = 4;
  localparam int SW_A_ONE_BIT   = 5;
  localparam int SW_B_ONE_BIT   = 6;
  localparam int SW_SHARED_BIT  = 7;
  localparam logic [7:0] DLY_ONE_MASK  = 8'h03;
  localparam logic [7:0] DLY_TWO_MASK  = 8'he0;
  localparam logic [7:0] DLY_FOUR_MASK = 8'h1c;
  localparam logic [7:0] READ_IDLE     = 8'h00;   // Unmapped offsets read zero

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_GOOD  = 2'b00,                           // System power-good
    MODE_LEVEL = 2'b01,                           // Level shifter
    MODE_BUS   = 2'b10                            // Driven from the serial bus
  } out_mode_t;

  typedef enum logic [1:0] {
    TMR_IDLE   = 2'b00,
    TMR_TIMING = 2'b01,
    TMR_GOOD   = 2'b10
  } timer_state_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_CTRL  = 2'b01,
    SEL_DELAY = 2'b10,
    SEL_SWDIS = 2'b11
  } reg_sel_t;

  // Delay code to number of 5 ms steps
  function automatic logic [4:0] delay_steps(input logic [2:0] code);
    case (code)
      3'h0:    delay_steps = 5'(DLY_MS_0 / DLY_STEP_MS);
      3'h1:    delay_steps = 5'(DLY_MS_1 / DLY_STEP_MS);
      3'h2:    delay_steps = 5'(DLY_MS_2 / DLY_STEP_MS);
      3'h3:    delay_steps = 5'(DLY_MS_3 / DLY_STEP_MS);
      3'h4:    delay_steps = 5'(DLY_MS_4 / DLY_STEP_MS);
      3'h5:    delay_steps = 5'(DLY_MS_5 / DLY_STEP_MS);
      3'h6:    delay_steps = 5'(DLY_MS_6 / DLY_STEP_MS);
      default: delay_steps = 5'(DLY_MS_7 / DLY_STEP_MS);
    endcase
  endfunction

  // Address decode shared by write and read paths
  function automatic reg_sel_t reg_decode(input logic [7:0] addr);
    case (addr)
      ADDR_CTRL:  reg_decode = SEL_CTRL;
      ADDR_DELAY: reg_decode = SEL_DELAY;
      ADDR_SWDIS: reg_decode = SEL_SWDIS;
      default:    reg_decode = SEL_NONE;
    endcase
  endfunction

endpackage

/* rtl/good_delay_timer.sv */
// Purpose : Times the power-good delay of one general-purpose output
// Assumes : rails_ok_in is high while every rail grouped to the pin is in regulation
// Notes   : The code is latched when timing starts; a new code applies to the next rise

`timescale 1ns/1ps

module good_delay_timer (
  input  wire logic        mclk_in,         // System clock
  input  wire logic        reset_in,        // Synchronous, active high
  input  wire logic        rails_ok_in,     // All grouped rails in regulation
  input  wire logic        delay_used_in,   // Delay field applies to this pin
  input  wire logic [2:0]  delay_code_in,   // Programmed delay code
  input  wire logic [31:0] step_cycles_in,  // Cycles per 5 ms step
  output logic             good_out         // Delayed power-good
);

  // ****************************************************************
  // State
  // ****************************************************************
  rail_pkg::timer_state_t state_q, state_d;
  logic [31:0] pre_q, pre_d;                // Cycles within the current step
  logic [4:0]  steps_q, steps_d;            // Steps completed
  logic [4:0]  target_q, target_d;          // Steps wanted, latched at start
  logic        good_q, good_d;
  logic [4:0]  start_steps;

  // An unused field counts as zero delay so it cannot hold the pin back
  assign start_steps = delay_used_in ? rail_pkg::delay_steps(delay_code_in) : 5'h00;

  // Next-state logic
  always_comb begin
    state_d  = state_q;
    pre_d    = pre_q;
    steps_d  = steps_q;
    target_d = target_q;
    good_d   = good_q;
    case (state_q)
      rail_pkg::TMR_IDLE: begin
        good_d = 1'b0;
        if (rails_ok_in) begin
          target_d = start_steps;                                        // RL3
          pre_d    = 32'h0000_0000;
          steps_d  = 5'h00;
          if (start_steps == 5'h00) begin
            state_d = rail_pkg::TMR_GOOD;
            good_d  = 1'b1;
          end else begin
            state_d = rail_pkg::TMR_TIMING;
          end
        end
      end
      rail_pkg::TMR_TIMING: begin
        // Losing regulation restarts the whole delay
        if (!rails_ok_in) begin
          state_d = rail_pkg::TMR_IDLE;
          good_d  = 1'b0;
        end else if (pre_q == step_cycles_in - 32'h0000_0001) begin
          pre_d = 32'h0000_0000;
          if (steps_q + 5'h01 == target_q) begin
            state_d = rail_pkg::TMR_GOOD;                                // RL3
            good_d  = 1'b1;
          end else begin
            steps_d = steps_q + 5'h01;
          end
        end else begin
          pre_d = pre_q + 32'h0000_0001;
        end
      end
      rail_pkg::TMR_GOOD: begin
        if (!rails_ok_in) begin
          state_d = rail_pkg::TMR_IDLE;
          good_d  = 1'b0;
        end
      end
      default: begin
        state_d = rail_pkg::TMR_IDLE;
        good_d  = 1'b0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q  <= rail_pkg::TMR_IDLE;
      pre_q    <= 32'h0000_0000;
      steps_q  <= 5'h00;
      target_q <= 5'h00;
      good_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      pre_q    <= pre_d;
      steps_q  <= steps_d;
      target_q <= target_d;
      good_q   <= good_d;
    end
  end

  assign good_out = good_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_good_needs_rails;
    @(posedge mclk_in) disable iff (reset_in)
    $rose(good_q) |-> $past(rails_ok_in);
  endproperty
  a_good_needs_rails: assert property (p_good_needs_rails) else $error("good rose without rails in regulation"); // RL3

endmodule

/* rtl/rail_control_pg_delay_regs.sv */
// Purpose : Rail mode, software disable and power-good delay registers with their effects
// Assumes : Register port comes from the serial interface decoder; OTP values are static
// Notes   : Register defaults are loaded from OTP inputs on the first edge after reset

`timescale 1ns/1ps

// Behaviour
// RL1: Mode bit 0 automatic, 1 forced PWM
// RL2: Controller disable bit 0 forces controller off
// RL3: Power-good asserts after delay from regulation
// RL4: Second output delay: eight codes, 0-100 ms
// RL5: Fourth output delay uses same eight codes
// RL6: First output delay: 0, 5, 10, 15 ms
// RL7: Delays accurate within ten percent
// RL8: Bus-driven second output ignores delay unless termination
// RL9: Bus-driven first/fourth outputs ignore delay field
// RL10: Outputs act as good, level shifter, bus
// RL11: Unused delay bits default to zero
// RL12: Switch/termination disable bit 0 forces off
// RL13: Shared bit target chosen by factory setting
// RL14: Host writes zero to reserved low bits
// RL15: Control reserved bits read zero, ignore writes
// RL16: Writes take effect without commit action
module rail_control_pg_delay_regs #(
  parameter int DELAY_STEP_CYCLES = rail_pkg::DLY_STEP_CYCLES   // Cycles per 5 ms step
) (
  input  wire logic       mclk_in,                  // System clock, 40 MHz
  input  wire logic       reset_in,                 // Synchronous, active high
  input  wire logic       reg_wr_in,                // Register write strobe
  input  wire logic [7:0] reg_addr_in,              // Register offset
  input  wire logic [7:0] reg_wdata_in,             // Write data
  output logic      [7:0] reg_rdata_out,            // Read data, one cycle after address
  input  wire logic [5:0] otp_ctrl_in,              // Factory defaults, control register
  input  wire logic [7:0] otp_delay_in,             // Factory defaults, delay register
  input  wire logic [7:0] otp_swdis_in,             // Factory defaults, switch register
  input  wire logic       shared_target_sel_in,     // 1: switch B two, 0: adjustable regulator one
  input  wire logic [1:0] out_one_mode_in,          // Output modes, out_mode_t coding
  input  wire logic [1:0] out_two_mode_in,
  input  wire logic [1:0] out_four_mode_in,
  input  wire logic       out_two_term_use_in,      // Second output enables termination
  input  wire logic [2:0] group_ok_in,              // Grouped rails in regulation: four, two, one
  input  wire logic [2:0] bus_level_in,             // Bus-set levels: four, two, one
  input  wire logic [6:0] rail_request_in,          // Control-pin or power-good requests per rail
  output logic      [2:0] ctrl_forced_pwm_out,      // Controller three..one forced PWM
  output logic      [2:0] ctrl_enable_out,          // Controller three..one enable
  output logic            termination_enable_out,
  output logic            switch_a_one_enable_out,
  output logic            switch_b_one_enable_out,
  output logic            switch_b_two_enable_out,
  output logic            reg_a_one_enable_out,
  output logic            general_output_one_out,
  output logic            general_output_two_out,
  output logic            general_output_four_out
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [5:0] ctrl_q;                       // Bits 5:0 of the control register
  logic [5:0] ctrl_d;
  logic [7:0] delay_q;                      // Power-good delay register
  logic [7:0] delay_d;
  logic [7:0] swdis_q;                      // Switch and termination disable register
  logic [7:0] swdis_d;
  logic       load_q;                       // OTP default load pending
  logic       load_d;
  logic [7:0] rdata_d;
  logic [7:0] otp_delay_masked;
  logic       use_one;                      // Delay field relevant per pin
  logic       use_two;
  logic       use_four;
  rail_pkg::reg_sel_t wr_sel, rd_sel;

  // Delay only matters for good or level-shift use; termination keeps pin two's alive
  assign use_one  = out_one_mode_in  != rail_pkg::MODE_BUS;                        // RL9
  assign use_four = out_four_mode_in != rail_pkg::MODE_BUS;                        // RL9
  assign use_two  = (out_two_mode_in != rail_pkg::MODE_BUS) || out_two_term_use_in; // RL8

  // Unused fields come out of OTP as zero
  assign otp_delay_masked = otp_delay_in & ((use_one  ? rail_pkg::DLY_ONE_MASK  : 8'h00) | // RL11
                                            (use_two  ? rail_pkg::DLY_TWO_MASK  : 8'h00) |
                                            (use_four ? rail_pkg::DLY_FOUR_MASK : 8'h00));

  assign wr_sel = rail_pkg::reg_decode(reg_addr_in);
  assign rd_sel = wr_sel;

  // Register next values: OTP load first, then host writes
  always_comb begin
    ctrl_d  = ctrl_q;
    delay_d = delay_q;
    swdis_d = swdis_q;
    load_d  = 1'b0;
    if (load_q) begin
      ctrl_d  = otp_ctrl_in;
      delay_d = otp_delay_masked;
      swdis_d = otp_swdis_in;
    end else if (reg_wr_in) begin
      case (wr_sel)
        rail_pkg::SEL_CTRL:  ctrl_d  = reg_wdata_in[rail_pkg::CTRL_WIDTH-1:0];     // RL15 RL16
        rail_pkg::SEL_DELAY: delay_d = reg_wdata_in;                               // RL16
        // Low nibble is stored as written; the host keeps it at zero
        rail_pkg::SEL_SWDIS: swdis_d = reg_wdata_in;                               // RL14
        default: begin
          // Unmapped offsets are ignored
        end
      endcase
    end
  end

  // Read mux; control reserved bits are never stored so they read zero
  always_comb begin
    case (rd_sel)
      rail_pkg::SEL_CTRL:  rdata_d = {2'b00, ctrl_q};                              // RL15
      rail_pkg::SEL_DELAY: rdata_d = delay_q;
      rail_pkg::SEL_SWDIS: rdata_d = swdis_q;
      default:             rdata_d = rail_pkg::READ_IDLE;
    endcase
  end

  // Register file flops; reset holds all-off until the OTP load a cycle later
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_q        <= 6'h00;
      delay_q       <= 8'h00;
      swdis_q       <= 8'h00;
      load_q        <= 1'b1;
      reg_rdata_out <= 8'h00;
    end else begin
      ctrl_q        <= ctrl_d;
      delay_q       <= delay_d;
      swdis_q       <= swdis_d;
      load_q        <= load_d;
      reg_rdata_out <= rdata_d;
    end
  end

  // ****************************************************************
  // Power-good delay timers
  // ****************************************************************
  logic good_one;
  logic good_two;
  logic good_four;

  // Exact 5 ms multiples, well inside the allowed tolerance
  good_delay_timer u_timer_one (                                                   // RL7
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .rails_ok_in    (group_ok_in[0]),
    .delay_used_in  (use_one),
    .delay_code_in  ({1'b0, delay_q[rail_pkg::DLY_ONE_LSB +: 2]}),                 // RL6
    .step_cycles_in (32'(DELAY_STEP_CYCLES)),
    .good_out       (good_one)
  );

  good_delay_timer u_timer_two (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .rails_ok_in    (group_ok_in[1]),
    .delay_used_in  (use_two),
    .delay_code_in  (delay_q[rail_pkg::DLY_TWO_LSB +: 3]),                         // RL4
    .step_cycles_in (32'(DELAY_STEP_CYCLES)),
    .good_out       (good_two)
  );

  good_delay_timer u_timer_four (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .rails_ok_in    (group_ok_in[2]),
    .delay_used_in  (use_four),
    .delay_code_in  (delay_q[rail_pkg::DLY_FOUR_LSB +: 3]),                        // RL5
    .step_cycles_in (32'(DELAY_STEP_CYCLES)),
    .good_out       (good_four)
  );

  // ****************************************************************
  // Rail enables and pin outputs
  // ****************************************************************
  logic [2:0] pwm_d;
  logic [2:0] ctrl_en_d;
  logic       term_d;
  logic       sw_a1_d;
  logic       sw_b1_d;
  logic       sw_b2_d;
  logic       reg_a1_d;
  logic       shared_on;
  logic       pin_one_d;
  logic       pin_two_d;
  logic       pin_four_d;

  // Software disable gates every request, whatever the pins ask for
  always_comb begin
    pwm_d     = ctrl_q[rail_pkg::CTRL_MODE_LSB +: 3];                              // RL1
    ctrl_en_d = rail_request_in[2:0] & ctrl_q[rail_pkg::CTRL_DIS_LSB +: 3];        // RL2

    // Pin two can enable termination from its own delayed good
    term_d    = (rail_request_in[3] | (out_two_term_use_in & good_two))
                & swdis_q[rail_pkg::SW_TERM_BIT];                                  // RL12
    sw_a1_d   = rail_request_in[4] & swdis_q[rail_pkg::SW_A_ONE_BIT];              // RL12
    sw_b1_d   = rail_request_in[5] & swdis_q[rail_pkg::SW_B_ONE_BIT];              // RL12
    shared_on = rail_request_in[6] & swdis_q[rail_pkg::SW_SHARED_BIT];             // RL12
    sw_b2_d   = shared_on & shared_target_sel_in;                                  // RL13
    reg_a1_d  = shared_on & ~shared_target_sel_in;                                 // RL13

    // Bus mode takes the level bit; good and level-shift take the delayed good
    pin_one_d  = (out_one_mode_in  == rail_pkg::MODE_BUS) ? bus_level_in[0] : good_one;  // RL10
    pin_two_d  = (out_two_mode_in  == rail_pkg::MODE_BUS) ? bus_level_in[1] : good_two;  // RL10
    pin_four_d = (out_four_mode_in == rail_pkg::MODE_BUS) ? bus_level_in[2] : good_four; // RL10
  end

  // Output flops; everything off during reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_forced_pwm_out     <= 3'h0;
      ctrl_enable_out         <= 3'h0;
      termination_enable_out  <= 1'b0;
      switch_a_one_enable_out <= 1'b0;
      switch_b_one_enable_out <= 1'b0;
      switch_b_two_enable_out <= 1'b0;
      reg_a_one_enable_out    <= 1'b0;
      general_output_one_out  <= 1'b0;
      general_output_two_out  <= 1'b0;
      general_output_four_out <= 1'b0;
    end else begin
      ctrl_forced_pwm_out     <= pwm_d;
      ctrl_enable_out         <= ctrl_en_d;
      termination_enable_out  <= term_d;
      switch_a_one_enable_out <= sw_a1_d;
      switch_b_one_enable_out <= sw_b1_d;
      switch_b_two_enable_out <= sw_b2_d;
      reg_a_one_enable_out    <= reg_a1_d;
      general_output_one_out  <= pin_one_d;
      general_output_two_out  <= pin_two_d;
      general_output_four_out <= pin_four_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_mode_follows;
    ##1 ctrl_forced_pwm_out == $past(ctrl_q[5:3]);
  endproperty
  a_mode_follows: assert property (p_mode_follows) else $error("mode output does not follow register"); // RL1

  property p_ctrl_off;
    !ctrl_q[0] |=> !ctrl_enable_out[0];
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) else $error("controller one on while disabled"); // RL2

  property p_term_off;
    !swdis_q[4] |=> !termination_enable_out;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination on while disabled"); // RL12

  property p_shared_target;
    shared_target_sel_in |=> !reg_a_one_enable_out;
  endproperty
  a_shared_target: assert property (p_shared_target) else $error("wrong shared rail target"); // RL13

  property p_reserved_zero;
    rd_sel == rail_pkg::SEL_CTRL |=> reg_rdata_out == {2'b00, $past(ctrl_q)};
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non-zero"); // RL15

  property p_write_delay;
    !load_q && reg_wr_in && reg_addr_in == rail_pkg::ADDR_DELAY |=> delay_q == $past(reg_wdata_in);
  endproperty
  a_write_delay: assert property (p_write_delay) else $error("delay write not stored"); // RL16

  property p_zero_delay;
    use_one && delay_q[1:0] == 2'b00 && out_one_mode_in == rail_pkg::MODE_GOOD && $rose(group_ok_in[0])
      ##1 group_ok_in[0] |=> general_output_one_out;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay good late"); // RL6

  property p_bus_level;
    out_four_mode_in == rail_pkg::MODE_BUS |=> general_output_four_out == $past(bus_level_in[2]);
  endproperty
  a_bus_level: assert property (p_bus_level) else $error("bus-driven pin ignores level"); // RL9

  property p_load_masks;
    load_q && !use_four |=> delay_q[4:2] == 3'b000;
  endproperty
  a_load_masks: assert property (p_load_masks) else $error("unused delay bits not zero"); // RL11

  property p_term_from_good;
    out_two_term_use_in && good_two && swdis_q[4] |=> termination_enable_out;
  endproperty
  a_term_from_good: assert property (p_term_from_good) else $error("termination ignores pin two good"); // RL8

  property p_b_two_off;
    !shared_target_sel_in |=> !switch_b_two_enable_out;
  endproperty
  a_b_two_off: assert property (p_b_two_off) else $error("switch B two on for regulator target"); // RL13

  c_ctrl_write: cover property (reg_wr_in && reg_addr_in == rail_pkg::ADDR_CTRL);
  c_pin_two_good: cover property ($rose(general_output_two_out));
  c_shared_b_two: cover property (switch_b_two_enable_out);
  c_term_from_good: cover property (out_two_term_use_in && termination_enable_out);

endmodule

/* bench/rail_host_model.sv */
// Purpose : Host stand-in that programs the register port
// Assumes : The block samples its port on the rising edge
// Notes   : Drives on the falling edge; one idle cycle between writes
`timescale 1ns/1ps
// ****************************************************************
// Host model
// ****************************************************************
module rail_host_model (
  input  wire logic       mclk_in,   // System clock
  input  wire logic [7:0] rdata_in,  // Read data from the block
  output logic            wr_out,    // Write strobe
  output logic      [7:0] addr_out,  // Register offset
  output logic      [7:0] wdata_out  // Write data
);
  // Idle port at time zero
  initial begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One write; the reserved low nibble of the switch register always goes out as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = (a == rail_pkg::ADDR_SWDIS) ? (d & 8'hf0) : d;
    @(negedge mclk_in);
    wr_out = 1'b0;
  endtask
  // Address held two edges so the registered answer has surely settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    addr_out = a;
    @(posedge mclk_in);
    @(posedge mclk_in);
    #1;
    d = rdata_in;
  endtask
endmodule

/* bench/rail_control_pg_delay_regs_test.sv */
// Purpose : Self-checking bench for the rail mode, disable and power-good delay registers
// Assumes : Delay step shortened to STEP cycles to keep the run short
// Notes   : Inputs change on the falling edge; outputs sampled just after the rising edge or at the falling edge
`timescale 1ns/1ps
`define chk(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
// ****************************************************************
// Bench top
// ****************************************************************
module rail_control_pg_delay_regs_test;
  localparam int STEP = 4;                        // Cycles per 5 ms step
  logic       clk, rst, tsel, tuse, sa1, sb1, sb2, ra1, term, wr;
  logic [7:0] otp_d, otp_s, addr, wdata, rdata, rv;
  logic [5:0] otp_c;                              // Control defaults
  logic [1:0] m1, m2, m4;                         // Output modes
  logic [2:0] gok, blev, pwm, en;
  logic [6:0] req;                                // Rail requests from pins
  wire  [2:0] pins;                               // Output pins four, two, one
  int         failures, total_checks;
  int         st [8] = '{0, 1, 2, 3, 4, 10, 15, 20}; // Steps per delay code
  rail_control_pg_delay_regs #(.DELAY_STEP_CYCLES(STEP)) i_rail_control_pg_delay_regs (
    .mclk_in(clk), .reset_in(rst), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .otp_ctrl_in(otp_c), .otp_delay_in(otp_d), .otp_swdis_in(otp_s),
    .shared_target_sel_in(tsel), .out_one_mode_in(m1), .out_two_mode_in(m2), .out_four_mode_in(m4),
    .out_two_term_use_in(tuse), .group_ok_in(gok), .bus_level_in(blev), .rail_request_in(req),
    .ctrl_forced_pwm_out(pwm), .ctrl_enable_out(en), .termination_enable_out(term),
    .switch_a_one_enable_out(sa1), .switch_b_one_enable_out(sb1), .switch_b_two_enable_out(sb2),
    .reg_a_one_enable_out(ra1), .general_output_one_out(pins[0]), .general_output_two_out(pins[1]),
    .general_output_four_out(pins[2]));
  rail_host_model i_rail_host_model (.mclk_in(clk), .rdata_in(rdata), .wr_out(wr), .addr_out(addr),
    .wdata_out(wdata));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Defaults after load; pins two and four start bus-driven so their delay bits clear
  task automatic t_reset();
    i_rail_host_model.rd(rail_pkg::ADDR_CTRL, rv);
    `chk(rv, 8'h27)
    i_rail_host_model.rd(rail_pkg::ADDR_DELAY, rv);
    `chk(rv, 8'h03)
    i_rail_host_model.rd(rail_pkg::ADDR_SWDIS, rv);
    `chk(rv, 8'hf0)
    `chk({pwm, en, term, sa1, sb1, sb2, ra1}, 11'b10011111110)
    $display("test reset done");
  endtask
  // Reserved bits, both polarities of mode and disable, an unmapped offset
  task automatic t_ctrl();
    i_rail_host_model.wr(rail_pkg::ADDR_CTRL, 8'hfe);
    i_rail_host_model.rd(rail_pkg::ADDR_CTRL, rv);
    `chk(rv, 8'h3e)
    `chk({pwm, en}, 6'b111110)
    i_rail_host_model.wr(rail_pkg::ADDR_CTRL, 8'h01);
    i_rail_host_model.wr(8'h9e, 8'h55);
    i_rail_host_model.rd(8'h9e, rv);
    `chk(rv, 8'h00)
    `chk({pwm, en}, 6'b000001)
    $display("test control done");
  endtask
  // Each switch disable bit gates its rail
  task automatic t_switch();
    i_rail_host_model.wr(rail_pkg::ADDR_SWDIS, 8'ha0);
    i_rail_host_model.rd(rail_pkg::ADDR_SWDIS, rv);
    `chk({term, sa1, sb1, sb2, ra1}, 5'b01010)
    @(negedge clk);
    tsel = 1'b0;
    @(negedge clk);
    `chk({sb2, ra1}, 2'b01)
    tsel = 1'b1;
    i_rail_host_model.wr(rail_pkg::ADDR_SWDIS, 8'h5f);
    i_rail_host_model.rd(rail_pkg::ADDR_SWDIS, rv);
    `chk(rv, 8'h50)
    `chk({term, sa1, sb1, sb2, ra1}, 5'b10100)
    $display("test switch done");
  endtask
  // Program one pin's code, raise its rails and count edges to power-good
  task automatic t_pin(input int p, input logic [2:0] c, input int steps);
    int n;
    n = 0;
    if (p == 0) i_rail_host_model.wr(rail_pkg::ADDR_DELAY, {6'h00, c[1:0]});
    else if (p == 1) i_rail_host_model.wr(rail_pkg::ADDR_DELAY, {c, 5'h00});
    else i_rail_host_model.wr(rail_pkg::ADDR_DELAY, {3'h0, c, 2'h0});
    @(negedge clk);
    gok[p] = 1'b1;
    while (pins[p] !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    `chk(n, 2 + steps * STEP)
    @(negedge clk);
    gok[p] = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `chk(pins[p], 1'b0)
  endtask
  // Every code on every pin; pin four runs as level shifter
  task automatic t_delay();
    @(negedge clk);
    {m2, m4} = 4'b0001;
    for (int c = 0; c < 8; c++) begin
      t_pin(1, 3'(c), st[c]);
      t_pin(2, 3'(c), st[c]);
      if (c < 4) t_pin(0, 3'(c), st[c]);
    end
    $display("test delay done");
  endtask
  // Bus-driven pins follow the bus level whatever the delay code; termination use keeps pin two's delay
  task automatic t_bus();
    @(negedge clk);
    {m1, m2, m4} = 6'b101010;
    i_rail_host_model.wr(rail_pkg::ADDR_DELAY, 8'hff);
    @(negedge clk);
    blev = 3'b111;
    @(posedge clk);
    #1;
    `chk(pins, 3'b111)
    @(negedge clk);
    {tuse, req[3], gok[1]} = 3'b101;
    repeat (st[7] * STEP + 1) @(negedge clk);
    `chk(term, 1'b0)
    @(negedge clk);
    `chk(term, 1'b1)
    $display("test bus done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    tsel = 1'b1;
    tuse = 1'b0;
    otp_c = 6'h27;
    otp_d = 8'hff;
    otp_s = 8'hf0;
    {m1, m2, m4} = 6'b001010;
    gok = 3'b000;
    blev = 3'b000;
    req = 7'h7f;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_ctrl();
    t_switch();
    t_delay();
    t_bus();
    summarize();
  end
  // Watchdog far beyond the run's length
  initial begin
    #(20000 * 25);
    failures++;
    summarize();
  end
endmodule
